// ---- plr_ctrl.sv ----
// framer-side controller: APB slave issuing router writes and PCM frames
// assumes software orders the writes; zero-wait APB, one core clock
`timescale 1ns/1ps
module plr_ctrl (
  input  wire logic        i_core_clk,   // core clock
  input  wire logic        i_nrst,       // sync reset, active low
  input  wire logic        i_psel,       // APB select
  input  wire logic        i_penable,    // APB enable
  input  wire logic        i_pwrite,     // APB write
  input  wire logic [31:0] i_paddr,      // APB address
  input  wire logic [31:0] i_pwdata,     // APB write data
  output logic      [31:0] o_prdata,     // APB read data
  output logic             o_pready,     // APB ready
  output logic             o_pslverr,    // unmapped address
  plr_link_if.ctl          link          // pins to the router
);

  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready;
  logic        slverr_ff, nxt_slverr;
  logic        wr_ff, nxt_wr;
  logic [7:0]  addr_ff, nxt_addr;
  logic [7:0]  wdata_ff, nxt_wdata;
  logic        run_ff, nxt_run;
  logic [5:0]  last_ff, nxt_last;
  logic [7:0]  tpat_ff, nxt_tpat;
  logic [7:0]  apat_ff, nxt_apat;
  logic [2:0]  bit_ff, nxt_bit;
  logic [5:0]  slot_ff, nxt_slot;
  logic        sync_ff, nxt_sync;
  logic        pcm_tx_serial_data_ff, nxt_pcm_tx_serial_data;
  logic        add_ff, nxt_add;
  logic [15:0] frames_ff, nxt_frames;
  logic [15:0] inscnt_ff, nxt_inscnt;

  function automatic logic mapped(input logic [31:0] a);
    return (a[31:8] == 24'h000000) && ((a[7:0] == plr_pkg::APB_CMD) || (a[7:0] == plr_pkg::APB_FRAME) ||
           (a[7:0] == plr_pkg::APB_PATT) || (a[7:0] == plr_pkg::APB_STAT));
  endfunction

  always_comb begin
    logic setup;
    logic wr_acc;
    setup      = i_psel && !i_penable;
    wr_acc     = i_psel && i_penable && pready_ff && i_pwrite && mapped(i_paddr);
    nxt_pready = setup;
    nxt_slverr = setup && !mapped(i_paddr);
    nxt_prdata = prdata_ff;
    nxt_wr     = 1'b0;
    nxt_addr   = addr_ff;
    nxt_wdata  = wdata_ff;
    nxt_run    = run_ff;
    nxt_last   = last_ff;
    nxt_tpat   = tpat_ff;
    nxt_apat   = apat_ff;
    if (setup) begin
      case (i_paddr[7:0])
        plr_pkg::APB_FRAME: nxt_prdata = {23'h000000, run_ff, 2'h0, last_ff};
        plr_pkg::APB_PATT:  nxt_prdata = {16'h0000, apat_ff, tpat_ff};
        plr_pkg::APB_STAT:  nxt_prdata = {frames_ff, inscnt_ff};
        default:            nxt_prdata = 32'h00000000;
      endcase
    end
    if (wr_acc) begin
      case (i_paddr[7:0])
        plr_pkg::APB_CMD: begin
          nxt_wr    = 1'b1;
          nxt_addr  = i_pwdata[15:8];
          nxt_wdata = i_pwdata[7:0];
        end
        plr_pkg::APB_FRAME: begin
          nxt_run  = i_pwdata[plr_pkg::FRM_RUN];
          nxt_last = i_pwdata[5:0];
        end
        plr_pkg::APB_PATT: begin
          nxt_tpat = i_pwdata[7:0];
          nxt_apat = i_pwdata[15:8];
        end
        default: begin
          nxt_wr = 1'b0;
        end
      endcase
    end
  end

  // frame generator: sync pulse on bit 0 of slot 0, data LSB first
  always_comb begin
    nxt_bit    = bit_ff;
    nxt_slot   = slot_ff;
    nxt_frames = frames_ff;
    nxt_inscnt = inscnt_ff + {15'h0000, link.insert};
    if (!run_ff) begin
      nxt_bit  = 3'h0;
      nxt_slot = 6'h00;
    end else begin
      nxt_bit = bit_ff + 3'h1;
      if (bit_ff == plr_pkg::BIT_LAST) begin
        nxt_slot = (slot_ff == last_ff) ? 6'h00 : slot_ff + 6'h01;
        if (slot_ff == last_ff) begin
          nxt_frames = frames_ff + 16'h0001;
        end
      end
    end
    nxt_sync = run_ff && (bit_ff == 3'h0) && (slot_ff == 6'h00);
    nxt_pcm_tx_serial_data = run_ff && tpat_ff[bit_ff];
    nxt_add  = run_ff && apat_ff[bit_ff];
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      slverr_ff <= 1'b0;
      wr_ff     <= 1'b0;
      addr_ff   <= 8'h00;
      wdata_ff  <= 8'h00;
      run_ff    <= 1'b0;
      last_ff   <= 6'h00;
      tpat_ff   <= 8'h00;
      apat_ff   <= 8'h00;
      bit_ff    <= 3'h0;
      slot_ff   <= 6'h00;
      sync_ff   <= 1'b0;
      pcm_tx_serial_data_ff   <= 1'b0;
      add_ff    <= 1'b0;
      frames_ff <= 16'h0000;
      inscnt_ff <= 16'h0000;
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      slverr_ff <= nxt_slverr;
      wr_ff     <= nxt_wr;
      addr_ff   <= nxt_addr;
      wdata_ff  <= nxt_wdata;
      run_ff    <= nxt_run;
      last_ff   <= nxt_last;
      tpat_ff   <= nxt_tpat;
      apat_ff   <= nxt_apat;
      bit_ff    <= nxt_bit;
      slot_ff   <= nxt_slot;
      sync_ff   <= nxt_sync;
      pcm_tx_serial_data_ff   <= nxt_pcm_tx_serial_data;
      add_ff    <= nxt_add;
      frames_ff <= nxt_frames;
      inscnt_ff <= nxt_inscnt;
    end
  end

  assign o_prdata                 = prdata_ff;
  assign o_pready                 = pready_ff;
  assign o_pslverr                = slverr_ff;
  assign link.mpu_wr              = wr_ff;
  assign link.mpu_addr            = addr_ff;
  assign link.mpu_wdata           = wdata_ff;
  assign link.pcm_frame_sync      = sync_ff;
  assign link.pcm_tx_serial_data  = pcm_tx_serial_data_ff;
  assign link.pcm_add_serial_data = add_ff;

endmodule

// ---- plr_link_asserts.sv ----
// checker on the link between controller and router
// assumes one core clock; instantiated beside the link interface
`timescale 1ns/1ps
module plr_link_asserts (
  input wire logic       i_core_clk,          // core clock
  input wire logic       i_nrst,              // sync reset, active low
  input wire logic       pcm_frame_sync,      // frame sync
  input wire logic       pcm_tx_serial_data,  // transmit bit
  input wire logic       pcm_add_serial_data, // insert bit
  input wire logic       insert,              // insert pin
  input wire logic       mpu_wr,              // write strobe
  input wire logic [7:0] mpu_addr,            // write address
  input wire logic [7:0] mpu_wdata            // write data
);
  logic       sync_q_ff, run_ff, en_ff, rise;
  logic [2:0] bit_ff, pos_bit;
  logic [5:0] slot_ff, ptr_ff, pos_slot;
  logic       tbl_ff [64];

  // slot position of the current cycle, restarted by a sync rise
  assign rise     = pcm_frame_sync & ~sync_q_ff;
  assign pos_bit  = rise ? 3'h0 : bit_ff + 3'h1;
  assign pos_slot = rise ? 6'h00 : slot_ff + {5'h00, bit_ff == 3'h7};

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      sync_q_ff <= 1'b0;
      run_ff    <= 1'b0;
      en_ff     <= 1'b0;
      bit_ff    <= 3'h0;
      slot_ff   <= 6'h00;
      ptr_ff    <= 6'h00;
      for (int i = 0; i < 64; i++) tbl_ff[i] <= 1'b0;
    end else begin
      sync_q_ff <= pcm_frame_sync;
      run_ff    <= run_ff | rise;
      bit_ff    <= pos_bit;
      slot_ff   <= pos_slot;
      if (mpu_wr && mpu_addr == plr_pkg::ADDR_CTRL) begin
        en_ff <= mpu_wdata[plr_pkg::CTL_ROUTE_EN];
        if (mpu_wdata[plr_pkg::CTL_ROUTE_EN] && !en_ff) ptr_ff <= 6'h00;
      end
      if (mpu_wr && mpu_addr == plr_pkg::ADDR_ROUTE && en_ff) begin
        tbl_ff[ptr_ff] <= mpu_wdata[plr_pkg::ENT_INS];
        ptr_ff         <= ptr_ff + 6'h01;
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  a_ins_slot_flag: assert property (run_ff |-> insert == tbl_ff[pos_slot])
    else $error("insert differs from the slot entry flag");
  a_ins_whole_slot: assert property (run_ff && pos_bit != 3'h0 |-> $stable(insert))
    else $error("insert changed inside a slot");
  a_ins_rise_edge: assert property (run_ff && $rose(insert) |-> pos_bit == 3'h0)
    else $error("insert rose off a slot boundary");
  a_ins_fall_edge: assert property (run_ff && $fell(insert) |-> pos_bit == 3'h0)
    else $error("insert fell off a slot boundary");
  a_wr_one_pulse: assert property (mpu_wr |=> !mpu_wr)
    else $error("write strobe longer than one cycle");
  a_sync_one_pulse: assert property (pcm_frame_sync |=> !pcm_frame_sync)
    else $error("frame sync longer than one cycle");
  a_sync_slot_gap: assert property (rise |=> !pcm_frame_sync [*7])
    else $error("frame sync inside the first slot");
  a_sync_on_bound: assert property (rise && run_ff |-> bit_ff == 3'h7)
    else $error("frame sync off a slot boundary");

  c_frame: cover property (rise && run_ff);
  c_insert: cover property ($rose(insert));
  c_route_wr: cover property (mpu_wr && mpu_addr == plr_pkg::ADDR_ROUTE);
  c_slot_data: cover property (rise && pcm_tx_serial_data && pcm_add_serial_data);
endmodule

// ---- plr_link_if.sv ----
// pins between the framer controller and the payload router
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface plr_link_if;
  logic       pcm_frame_sync;
  logic       pcm_tx_serial_data;
  logic       pcm_add_serial_data;
  logic       insert;
  logic       mpu_wr;
  logic [7:0] mpu_addr;
  logic [7:0] mpu_wdata;

  modport dev (
    input  pcm_frame_sync,
    input  pcm_tx_serial_data,
    input  pcm_add_serial_data,
    input  mpu_wr,
    input  mpu_addr,
    input  mpu_wdata,
    output insert
  );

  modport ctl (
    output pcm_frame_sync,
    output pcm_tx_serial_data,
    output pcm_add_serial_data,
    output mpu_wr,
    output mpu_addr,
    output mpu_wdata,
    input  insert
  );
endinterface

// ---- plr_pkg.sv ----
// constants and types shared by the payload router and its controller
// assumes one core clock; all ports synchronous to it
package plr_pkg;
  // device write-port addresses
  localparam logic [7:0] ADDR_BANK1 = 8'hDC;
  localparam logic [7:0] ADDR_BANK2 = 8'hDD;
  localparam logic [7:0] ADDR_BANK3 = 8'hDE;
  localparam logic [7:0] ADDR_STUFF = 8'hE4;
  localparam logic [7:0] ADDR_CTRL  = 8'hE7;
  localparam logic [7:0] ADDR_FILL  = 8'hEA;
  localparam logic [7:0] ADDR_ROUTE = 8'hED;

  // control register bit positions and width
  localparam int unsigned CTL_ROUTE_EN = 0;
  localparam int unsigned CTL_PATTERN_GENERATOR_DISABLE = 1;
  localparam int unsigned CTL_PATTERN_GENERATOR_RESTART = 2;
  localparam int unsigned CTL_GROOM    = 3;
  localparam int unsigned CTL_AUX      = 4;
  localparam int unsigned CTL_W        = 5;

  // table entry layout and routing codes
  localparam int unsigned ENT_W   = 7;
  localparam int unsigned ENT_INS = 6;
  localparam int unsigned NUM_CH  = 3;
  localparam int unsigned NUM_ENT = 64;
  localparam logic [1:0] RT_DISCARD = 2'h0;
  localparam logic [1:0] RT_PCM_TX_SERIAL_DATA    = 2'h1;
  localparam logic [1:0] RT_PATT    = 2'h2;
  localparam logic [1:0] RT_DELAY   = 2'h3;

  localparam logic [2:0]  BIT_LAST  = 3'h7;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [3:0]  RST_STUFF = 4'h0;
  localparam logic [14:0] RST_LFSR  = 15'h0001;
  localparam logic [6:0]  LFSR_HI0  = 7'h00;

  // controller APB offsets and the FRAME register run bit
  localparam logic [7:0] APB_CMD   = 8'h00;
  localparam logic [7:0] APB_FRAME = 8'h04;
  localparam logic [7:0] APB_PATT  = 8'h08;
  localparam logic [7:0] APB_STAT  = 8'h0C;
  localparam int unsigned FRM_RUN  = 8;

  typedef enum logic [1:0] {
    PLR_IDLE = 2'b00,
    PLR_RUN  = 2'b01
  } plr_state_t;
endpackage

// ---- plr_router.sv ----
// transmit payload router: routing table, delay buffer, pattern source, banks
// assumes one serial bit per core clock, frame sync synchronous to the clock
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module plr_router (
  input  wire logic        i_core_clk,       // core clock
  input  wire logic        i_nrst,           // sync reset, active low
  plr_link_if.dev          link,             // pins to the controller
  output logic [23:0]      o_ch_data,        // byte per channel, ch1 low
  output logic [2:0]       o_ch_valid,       // byte strobe per channel
  output logic [7:0]       o_bank_one,       // bank pattern one
  output logic [7:0]       o_bank_two,       // bank pattern two
  output logic [7:0]       o_bank_three,     // bank pattern three
  output logic             o_rx_groom_on,    // bank three is signaling buffer
  output logic             o_tx_aux_on,      // bank three holds aux data
  output logic [7:0]       o_ber_pattern,    // reference for the error meter
  output logic [3:0]       o_stuff_bits      // stuff value, bit 0 sent first
);

  function automatic logic [14:0] plr_step8(input logic [14:0] s);
    logic [14:0] r;
    r = s;
    for (int k = 0; k < 8; k++) begin
      r = {r[13:0], r[14] ^ r[13]};
    end
    return r;
  endfunction

  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] want);
    return wr && (a == want);
  endfunction

  plr_pkg::plr_state_t                 state_ff, nxt_state;
  logic [plr_pkg::CTL_W-1:0]           ctrl_ff, nxt_ctrl;
  logic [3:0]                          stuff_ff, nxt_stuff;
  logic [7:0]                          fill_ff, nxt_fill;
  logic [7:0]                          bank_ff [3];
  logic [7:0]                          nxt_bank [3];
  logic [plr_pkg::ENT_W-1:0]           table_ff [plr_pkg::NUM_ENT];
  logic [plr_pkg::ENT_W-1:0]           nxt_table [plr_pkg::NUM_ENT];
  logic [5:0]                          ptr_ff, nxt_ptr;
  logic                                sync_d_ff, nxt_sync_d;
  logic [2:0]                          bit_ff, nxt_bit;
  logic [5:0]                          slot_ff, nxt_slot;
  logic [7:0]                          tsh_ff, nxt_tsh;
  logic [7:0]                          ash_ff, nxt_ash;
  logic [7:0]                          dly_ff, nxt_dly;
  logic [14:0]                         lfsr_ff, nxt_lfsr;
  logic                                ins_ff, nxt_ins;
  logic [23:0]                         chd_ff, nxt_chd;
  logic [2:0]                          chv_ff, nxt_chv;
  logic [7:0]                          ber_ff, nxt_ber;

  // write port and configuration
  always_comb begin
    logic ctl_wr;
    ctl_wr    = wr_hit(link.mpu_wr, link.mpu_addr, plr_pkg::ADDR_CTRL);
    nxt_ctrl  = ctrl_ff;
    nxt_stuff = stuff_ff;
    nxt_fill  = fill_ff;
    nxt_bank  = bank_ff;
    nxt_table = table_ff;
    nxt_ptr   = ptr_ff;
    if (ctl_wr) begin
      nxt_ctrl = link.mpu_wdata[plr_pkg::CTL_W-1:0];
      nxt_ctrl[plr_pkg::CTL_PATTERN_GENERATOR_RESTART] = 1'b0;
      if (link.mpu_wdata[plr_pkg::CTL_ROUTE_EN] && !ctrl_ff[plr_pkg::CTL_ROUTE_EN]) begin
        nxt_ptr = 6'h00;
      end
    end
    if (wr_hit(link.mpu_wr, link.mpu_addr, plr_pkg::ADDR_BANK1)) begin
      nxt_bank[0] = link.mpu_wdata;
    end
    if (wr_hit(link.mpu_wr, link.mpu_addr, plr_pkg::ADDR_BANK2)) begin
      nxt_bank[1] = link.mpu_wdata;
    end
    if (wr_hit(link.mpu_wr, link.mpu_addr, plr_pkg::ADDR_BANK3)) begin
      nxt_bank[2] = link.mpu_wdata;
    end
    if (wr_hit(link.mpu_wr, link.mpu_addr, plr_pkg::ADDR_STUFF)) begin
      nxt_stuff = link.mpu_wdata[3:0];
    end
    if (wr_hit(link.mpu_wr, link.mpu_addr, plr_pkg::ADDR_FILL)) begin
      nxt_fill = link.mpu_wdata;
    end
    // table writes only while access stays enabled
    if (wr_hit(link.mpu_wr, link.mpu_addr, plr_pkg::ADDR_ROUTE) && ctrl_ff[plr_pkg::CTL_ROUTE_EN]) begin
      nxt_table[ptr_ff] = link.mpu_wdata[plr_pkg::ENT_W-1:0];
      nxt_ptr = ptr_ff + 6'h01;
    end
  end

  // slot timing, capture and routing
  always_comb begin
    logic                      rise;
    logic                      slot_end;
    logic [7:0]                tbyte;
    logic [7:0]                abyte;
    logic [7:0]                patt;
    logic [plr_pkg::ENT_W-1:0] ent;
    logic [1:0]                code;
    logic                      patt_used;
    logic                      restart;
    rise      = link.pcm_frame_sync && !sync_d_ff;
    tbyte     = {link.pcm_tx_serial_data, tsh_ff[7:1]};
    abyte     = {link.pcm_add_serial_data, ash_ff[7:1]};
    ent       = table_ff[slot_ff];
    slot_end  = (state_ff == plr_pkg::PLR_RUN) && (bit_ff == plr_pkg::BIT_LAST) && !rise;
    patt      = ctrl_ff[plr_pkg::CTL_PATTERN_GENERATOR_DISABLE] ? fill_ff : lfsr_ff[7:0];
    patt_used = 1'b0;
    code      = plr_pkg::RT_DISCARD;
    restart   = wr_hit(link.mpu_wr, link.mpu_addr, plr_pkg::ADDR_CTRL) &&
                link.mpu_wdata[plr_pkg::CTL_PATTERN_GENERATOR_RESTART] && !nxt_ctrl[plr_pkg::CTL_PATTERN_GENERATOR_DISABLE];
    nxt_sync_d = link.pcm_frame_sync;
    nxt_state  = state_ff;
    nxt_bit    = bit_ff;
    nxt_slot   = slot_ff;
    nxt_tsh    = tbyte;
    nxt_ash    = abyte;
    nxt_dly    = dly_ff;
    nxt_chd    = chd_ff;
    nxt_chv    = 3'h0;
    nxt_ber    = patt;
    if (rise) begin
      nxt_state = plr_pkg::PLR_RUN;
      nxt_bit   = 3'h1;
      nxt_slot  = 6'h00;
    end else if (state_ff == plr_pkg::PLR_RUN) begin
      nxt_bit = bit_ff + 3'h1;
      if (bit_ff == plr_pkg::BIT_LAST) begin
        nxt_slot = slot_ff + 6'h01;
      end
    end
    if (slot_end) begin
      for (int c = 0; c < plr_pkg::NUM_CH; c++) begin
        code = ent[2*c +: 2];
        nxt_chv[c] = (code != plr_pkg::RT_DISCARD);
        case (code)
          plr_pkg::RT_PCM_TX_SERIAL_DATA: begin
            nxt_chd[8*c +: 8] = tbyte;
          end
          plr_pkg::RT_PATT: begin
            nxt_chd[8*c +: 8] = patt;
            patt_used = 1'b1;
          end
          plr_pkg::RT_DELAY: begin
            nxt_chd[8*c +: 8] = dly_ff;
          end
          default: begin
            nxt_chd[8*c +: 8] = chd_ff[8*c +: 8];
          end
        endcase
      end
      nxt_dly = ent[plr_pkg::ENT_INS] ? abyte : tbyte;
    end
    nxt_lfsr = lfsr_ff;
    if (restart) begin
      nxt_lfsr = {plr_pkg::LFSR_HI0, fill_ff};
    end else if (patt_used && !ctrl_ff[plr_pkg::CTL_PATTERN_GENERATOR_DISABLE]) begin
      nxt_lfsr = plr_step8(lfsr_ff);
    end
    nxt_ins = (nxt_state == plr_pkg::PLR_RUN) && table_ff[nxt_slot][plr_pkg::ENT_INS];
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      state_ff  <= plr_pkg::PLR_IDLE;
      ctrl_ff   <= '0;
      stuff_ff  <= plr_pkg::RST_STUFF;
      fill_ff   <= plr_pkg::RST_BYTE;
      bank_ff   <= '{default: plr_pkg::RST_BYTE};
      table_ff  <= '{default: '0};
      ptr_ff    <= 6'h00;
      sync_d_ff <= 1'b0;
      bit_ff    <= 3'h0;
      slot_ff   <= 6'h00;
      tsh_ff    <= plr_pkg::RST_BYTE;
      ash_ff    <= plr_pkg::RST_BYTE;
      dly_ff    <= plr_pkg::RST_BYTE;
      lfsr_ff   <= plr_pkg::RST_LFSR;
      ins_ff    <= 1'b0;
      chd_ff    <= 24'h000000;
      chv_ff    <= 3'h0;
      ber_ff    <= plr_pkg::RST_BYTE;
    end else begin
      state_ff  <= nxt_state;
      ctrl_ff   <= nxt_ctrl;
      stuff_ff  <= nxt_stuff;
      fill_ff   <= nxt_fill;
      bank_ff   <= nxt_bank;
      table_ff  <= nxt_table;
      ptr_ff    <= nxt_ptr;
      sync_d_ff <= nxt_sync_d;
      bit_ff    <= nxt_bit;
      slot_ff   <= nxt_slot;
      tsh_ff    <= nxt_tsh;
      ash_ff    <= nxt_ash;
      dly_ff    <= nxt_dly;
      lfsr_ff   <= nxt_lfsr;
      ins_ff    <= nxt_ins;
      chd_ff    <= nxt_chd;
      chv_ff    <= nxt_chv;
      ber_ff    <= nxt_ber;
    end
  end

  // banks read freely by both directions
  assign o_bank_one    = bank_ff[0];
  assign o_bank_two    = bank_ff[1];
  assign o_bank_three  = bank_ff[2];
  assign o_rx_groom_on = ctrl_ff[plr_pkg::CTL_GROOM];
  assign o_tx_aux_on   = ctrl_ff[plr_pkg::CTL_AUX];
  assign o_ber_pattern = ber_ff;
  assign o_stuff_bits  = stuff_ff;
  assign o_ch_data     = chd_ff;
  assign o_ch_valid    = chv_ff;
  assign link.insert   = ins_ff;

endmodule

// ---- test_pcm_line_payload_router.sv ----
// self-checking bench: APB drives the controller, router outputs compared
// assumes package, interface, design and checker compiled first
`timescale 1ns/1ps
module test_pcm_line_payload_router;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, er;
  logic        watch, stop, sq, groom, aux;
  logic [31:0] paddr, pwdata, prdata, rd, seed;
  logic [23:0] ch_data;
  logic [2:0]  ch_valid;
  logic [7:0]  b1, b2, b3, ber, fill, tp, ap, ex;
  logic [3:0]  stuff;
  logic [1:0]  code;
  logic [7:0]  eb [3];
  logic [6:0]  tbl [8];
  logic [7:0]  expq [3][$];
  int          fail_count, tests_run, cyc, qn;

  plr_link_if lk ();
  plr_ctrl u_plr_ctrl (.i_core_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .link(lk));
  plr_router u_plr_router (.i_core_clk(clk), .i_nrst(nrst), .link(lk), .o_ch_data(ch_data),
    .o_ch_valid(ch_valid), .o_bank_one(b1), .o_bank_two(b2), .o_bank_three(b3),
    .o_rx_groom_on(groom), .o_tx_aux_on(aux), .o_ber_pattern(ber), .o_stuff_bits(stuff));
  plr_link_asserts u_plr_link_asserts (.i_core_clk(clk), .i_nrst(nrst),
    .pcm_frame_sync(lk.pcm_frame_sync), .pcm_tx_serial_data(lk.pcm_tx_serial_data),
    .pcm_add_serial_data(lk.pcm_add_serial_data), .insert(lk.insert), .mpu_wr(lk.mpu_wr),
    .mpu_addr(lk.mpu_addr), .mpu_wdata(lk.mpu_wdata));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic rnd(output logic [7:0] v);
    seed = xs(seed);
    v = seed[7:0];
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, {24'h0, plr_pkg::APB_CMD}, {16'h0, a, d}, rd, er);
  endtask

  task automatic ctl(input logic [7:0] d);
    cmd(plr_pkg::ADDR_CTRL, d);
    repeat (4) @(posedge clk);
  endtask

  // result watcher, armed by the first frame sync
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end else begin
      if (watch && !stop) for (int c = 0; c < 3; c++) if (ch_valid[c] === 1'b1) begin
        if (expq[c].size() == 0) chk("extra", 1, 0);
        else chk("ch_data", expq[c].pop_front(), ch_data[8*c+:8]);
      end
      if (lk.pcm_frame_sync === 1'b1 && !sq) watch <= 1'b1;
      sq <= lk.pcm_frame_sync;
    end
  end

  initial begin
    seed = 32'd71970;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    watch = 1'b0;
    stop = 1'b0;
    sq = 1'b0;
    cyc = 0;
    fail_count = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("reset", 0, {b1, b2, b3, stuff, groom, aux});
    // pattern output lags the generator by one cycle, still at reset value here
    chk("ber_rst", plr_pkg::RST_BYTE, ber);
    for (int i = 0; i < 3; i++) begin
      rnd(eb[i]);
      cmd(8'(plr_pkg::ADDR_BANK1 + i), eb[i]);
    end
    rnd(fill);
    fill[0] = 1'b1;
    cmd(plr_pkg::ADDR_FILL, fill);
    rnd(ex);
    cmd(plr_pkg::ADDR_STUFF, ex);
    repeat (4) @(posedge clk);
    chk("banks", {eb[0], eb[1], eb[2]}, {b1, b2, b3});
    chk("stuff", ex[3:0], stuff);
    chk("ber_hold", plr_pkg::RST_LFSR[7:0], ber);
    ctl(8'h04);
    chk("ber_seed", fill, ber);
    repeat (150) @(posedge clk);
    chk("ber_idle", fill, ber);
    ctl(8'h0A);
    chk("groom", {fill, 2'b10}, {ber, groom, aux});
    ctl(8'h12);
    chk("aux", {fill, 2'b01}, {ber, groom, aux});
    tbl[0] = 7'h09;
    tbl[1] = 7'h13;
    tbl[2] = 7'h46;
    tbl[3] = 7'h3F;
    for (int i = 4; i < 8; i++) begin
      rnd(ex);
      tbl[i] = {1'b0, ex[5:0]};
    end
    ctl(8'h03);
    for (int i = 0; i < 68; i++) cmd(plr_pkg::ADDR_ROUTE, (i < 4) ? 8'h7F :
      (i < 8 || i > 63) ? {1'b0, tbl[i%8]} : 8'h00);
    ctl(8'h02);
    cmd(plr_pkg::ADDR_ROUTE, 8'h7F);
    rnd(tp);
    rnd(ap);
    apb(1'b1, {24'h0, plr_pkg::APB_PATT}, {16'h0, ap, tp}, rd, er);
    apb(1'b0, {24'h0, plr_pkg::APB_PATT}, 32'h0, rd, er);
    chk("patt_rd", {16'h0, ap, tp}, rd);
    for (int f = 0; f < 6; f++) for (int s = 0; s < 8; s++) for (int c = 0; c < 3; c++) begin
      code = tbl[s][2*c+:2];
      ex = (code == 2'h1) ? tp : (code == 2'h2) ? fill : tbl[(s+7)%8][6] ? ap : tp;
      if (code != 2'h0) expq[c].push_back(ex);
    end
    qn = expq[0].size();
    apb(1'b1, {24'h0, plr_pkg::APB_FRAME}, 32'h107, rd, er);
    rd = 32'h0;
    while ((rd[31:16] >= 16'd3) !== 1'b1) apb(1'b0, {24'h0, plr_pkg::APB_STAT}, 32'h0, rd, er);
    stop <= 1'b1;
    apb(1'b1, {24'h0, plr_pkg::APB_FRAME}, 32'h0, rd, er);
    chk("drained", 1, expq[0].size() < qn * 2 / 3);
    apb(1'b1, 32'h10, 32'h1, rd, er);
    chk("slverr_w", 1, er);
    apb(1'b0, 32'h100, 32'h0, rd, er);
    chk("slverr_r", {1'b1, 32'h0}, {er, rd});
    give_verdict();
  end
endmodule
